//--- src/rail_seq_pkg.sv
// Constants and timing for the three-rail power sequencer.
// Notes on behaviour
// - One enable input, three open-drain rail flags.
// - Release first, second, third, each after delay.
// - Power down reverses order: third, second, first.
// - Invert input flips active level of flags.
// - First step waits nine to ten ticks.
// - Later steps follow exactly eight ticks apart.
// - Flags stay inactive until enable first seen, except during reset with invert high (driven low).
// - Early enable loss clears counter, stays idle.
// - Enable loss mid power-up reverses released flags.
// - Invert low means active flag released high.
package rail_seq_pkg;
    localparam int          CLK_HZ            = 25000000;
    localparam int          TICK_PERIOD_US    = 1200;
    localparam int          TICK_CYCLES       = (CLK_HZ / 1000000) * TICK_PERIOD_US;
    localparam int          TICK_CNT_W        = 16;
    localparam logic [3:0]  FIRST_STEP_TICKS  = 4'h9;
    localparam logic [3:0]  NEXT_STEP_TICKS   = 4'h8;
    localparam logic [1:0]  STAGE_NONE        = 2'h0;
    localparam logic [1:0]  STAGE_ALL         = 2'h3;
    localparam logic [2:0]  RAIL_RESET        = 3'h0;
endpackage : rail_seq_pkg

//--- src/rail_sequencer.sv
// Three-rail power sequencer top with open-drain flag pins.
`timescale 1ns/1ns
`default_nettype none
module rail_sequencer #(
    parameter int TICK_CYCLES = rail_seq_pkg::TICK_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    input  wire logic       enable_i,
    input  wire logic       flag_polarity_invert_i,
    input  wire logic [2:0] rail_release_i,
    output logic      [2:0] rail_release_o,
    output logic      [2:0] rail_release_oe_o
);
    import rail_seq_pkg::*;

    // ***************************************************
    // Tick divider and enable sampling.
    // ***************************************************
    logic       tick;
    logic       en_meta_q;
    logic       en_q;
    logic [3:0] cnt_q;
    logic [1:0] stage_q;
    logic [2:0] rail_on;
    logic       dir_q;
    logic       fresh_q;
    logic [1:0] stage_prev_q;
    logic [3:0] gap_q;

    seq_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .tick_o    (tick)
    );

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            en_meta_q <= 1'b0;
            en_q      <= 1'b0;
        end else if (tick) begin
            en_meta_q <= enable_i;
            en_q      <= en_meta_q;
        end
    end

    // ***************************************************
    // Step counter and stage.
    // ***************************************************
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            dir_q   <= 1'b0;
            fresh_q <= 1'b1;
            cnt_q   <= 4'h0;
            stage_q <= STAGE_NONE;
        end else if (tick) begin
            if (en_q != dir_q) begin
                // A turn restarts the count, and this tick is the first one counted, except a turn off at STAGE_NONE, which leaves the count at zero.
                dir_q   <= en_q;
                fresh_q <= 1'b1;
                if (en_q || stage_q != STAGE_NONE) begin
                    cnt_q <= 4'h1;
                end else begin
                    cnt_q <= 4'h0;
                end
            end else if (dir_q ? stage_q != STAGE_ALL : stage_q != STAGE_NONE) begin
                if (cnt_q + 4'h1 >= (fresh_q ? FIRST_STEP_TICKS - 4'h1
                                             : NEXT_STEP_TICKS)) begin
                    cnt_q   <= 4'h0;
                    fresh_q <= 1'b0;
                    if (dir_q) begin
                        stage_q <= stage_q + 2'h1;
                    end else begin
                        stage_q <= stage_q - 2'h1;
                    end
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end else begin
                cnt_q   <= 4'h0;
                fresh_q <= 1'b1;
            end
        end
    end

    // ***************************************************
    // Flag pins.
    // ***************************************************
    always_comb begin
        rail_on = {stage_q == 2'h3, stage_q >= 2'h2, stage_q >= 2'h1};
    end

    genvar i;
    for (i = 0; i < 3; i++) begin : g_flag
        always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
                rail_release_o[i]    <= RAIL_RESET[i];
                rail_release_oe_o[i] <= 1'b1;
            end else begin
                rail_release_o[i]    <= 1'b0;
                rail_release_oe_o[i] <= !(rail_on[i] ^ flag_polarity_invert_i);
            end
        end

        AST_PIN_LOW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
            rail_release_oe_o[i] |-> !rail_release_i[i])
            else $error("Pulled-down flag pin reads high.");

        AST_FLAG_POL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
            ##1 rail_release_oe_o[i] == !($past(rail_on[i]) ^ $past(flag_polarity_invert_i)))
            else $error("Flag polarity wrong on one rail.");
    end

    // ***************************************************
    // Check helpers.
    // ***************************************************
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stage_prev_q <= STAGE_NONE;
        end else begin
            stage_prev_q <= stage_q;
        end
    end

    // Ticks since the last stage change or the last turn of direction.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gap_q <= 4'h0;
        end else if (stage_q != stage_prev_q) begin
            gap_q <= 4'h0;
        end else if (tick && en_q != dir_q) begin
            gap_q <= 4'h0;
        end else if (tick && gap_q != 4'hf) begin
            gap_q <= gap_q + 4'h1;
        end
    end

    // ***************************************************
    // Sequence checks.
    // ***************************************************
    AST_UP_ORDER: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q != stage_prev_q && dir_q) |-> stage_q == stage_prev_q + 2'h1)
        else $error("Power up step out of order.");
    AST_DOWN_ORDER: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q != stage_prev_q && !dir_q) |-> stage_q == stage_prev_q - 2'h1)
        else $error("Power down step out of order.");
    AST_TURN_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (tick && en_q != dir_q) |=> $stable(stage_q))
        else $error("Stage moved on a turn of direction.");
    AST_TURN_FRESH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (tick && en_q != dir_q) |=> fresh_q)
        else $error("Turn did not restart the first delay.");
    AST_CNT_IDLE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (tick && !en_q && stage_q == STAGE_NONE) |=> cnt_q == 4'h0)
        else $error("Counter not cleared while idle.");
    AST_ALL_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (en_q && stage_q == STAGE_ALL) |=> stage_q == STAGE_ALL)
        else $error("Full power left while enabled.");
    AST_LADDER_HI: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rail_on[2] |-> rail_on[1])
        else $error("Third rail on without second.");
    AST_LADDER_LO: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rail_on[1] |-> rail_on[0])
        else $error("Second rail on without first.");

    // ***************************************************
    // Timing checks.
    // ***************************************************
    AST_GAP_FIRST: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q != stage_prev_q && $past(fresh_q)) |-> gap_q == FIRST_STEP_TICKS - 4'h2)
        else $error("First step delay wrong.");
    AST_GAP_NEXT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q != stage_prev_q && !$past(fresh_q)) |-> gap_q == NEXT_STEP_TICKS)
        else $error("Later step delay wrong.");
    AST_TICK_PULSE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        tick |=> !tick)
        else $error("Tick longer than one cycle.");
    AST_DIR_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        tick |=> dir_q == $past(en_q))
        else $error("Direction missed the sampled enable.");
    AST_RESET_EXIT: assert property (@(posedge clk_sys_i)
        $fell(srst_i) |-> rail_release_oe_o == 3'h7)
        else $error("Flags not inactive out of reset.");

    // ***************************************************
    // Checks.
    // ***************************************************
    AST_IDLE_LOW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (!en_q && stage_q == STAGE_NONE) |=> $stable(stage_q))
        else $error("Stage moved while idle.");
    AST_STEP_ONE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q != $past(stage_q)) |-> (stage_q - $past(stage_q) == 2'h1
         || $past(stage_q) - stage_q == 2'h1))
        else $error("Stage skipped a step.");
    AST_DRIVE_LOW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rail_release_o == 3'h0)
        else $error("Flag driven high.");
    AST_CNT_RANGE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cnt_q < NEXT_STEP_TICKS)
        else $error("Step counter overran.");
    AST_POL: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ##1 rail_release_oe_o[0] == !($past(rail_on[0]) ^ $past(flag_polarity_invert_i)))
        else $error("Flag polarity wrong.");
    AST_NO_EARLY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (stage_q == STAGE_NONE) |-> !rail_on[0])
        else $error("Flag released while idle.");
    AST_TICK_ONLY: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !tick |=> $stable(stage_q))
        else $error("Stage moved without tick.");
    AST_SYNC: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !tick |=> $stable(en_q))
        else $error("Enable sampled off tick.");
endmodule : rail_sequencer
`default_nettype wire

//--- src/seq_tick_gen.sv
// Divider making the one-cycle internal sequencing tick.
`timescale 1ns/1ns
`default_nettype none
module seq_tick_gen #(
    parameter int TICK_CYCLES = 30000
) (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    output logic      tick_o
);
    import rail_seq_pkg::*;
    logic [TICK_CNT_W-1:0] cnt_q;
    localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(TICK_CYCLES - 1);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        tick_o <= !srst_i && (cnt_q == LAST);
    end
endmodule : seq_tick_gen
`default_nettype wire

//--- verif/rail_load_model.sv
// Regulator enable pins with pull-ups, loaded by the open-drain flags.
`timescale 1ns/1ns
`default_nettype none
module rail_load_model (
    input  wire logic [2:0] data_i,
    input  wire logic [2:0] oe_i,
    output logic      [2:0] pin_o
);
    // A driven pin shows the flag data, and a released pin floats up to high.
    assign pin_o = (oe_i & data_i) | ~oe_i;
endmodule : rail_load_model
`default_nettype wire

//--- verif/test_rail_sequencer.sv
// Self-checking bench for the three-rail power sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_rail_sequencer;
    import rail_seq_pkg::*;
    localparam int T = 4;
    logic       clk_sys_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       enable_i = 1'b0;
    logic       pol_flip = 1'b0;
    logic [2:0] pin;
    logic [2:0] dout;
    logic [2:0] oe;
    int         error_cnt = 0;
    int         total_checks = 0;
    initial forever #20 clk_sys_i = ~clk_sys_i;
    rail_sequencer #(.TICK_CYCLES(T)) u_rail_sequencer (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .enable_i(enable_i), .flag_polarity_invert_i(pol_flip), .rail_release_i(pin),
        .rail_release_o(dout), .rail_release_oe_o(oe));
    rail_load_model u_rail_load_model (.data_i(dout), .oe_i(oe), .pin_o(pin));
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // Waits a bounded time for one flag to change, then judges the time and all pins.
    task automatic step(input int b, input logic v, input int lo, input int hi,
                        input logic [2:0] pins);
        int n;
        n = 0;
        while (oe[b] !== v && n < 400) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        check("step_time", 1'b1, n >= lo && n <= hi);
        check("pins", pins, pin);
        if (n >= 400) final_report();
    endtask : step
    task automatic drive_en(input logic v);
        @(posedge clk_sys_i);
        enable_i <= v;
    endtask : drive_en
    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1 check("reset_oe", 3'h7, oe);
        repeat (50) @(posedge clk_sys_i);
        #1 check("idle_pins", 3'h0, pin);
        drive_en(1'b1);
        step(0, 1'b0, 9*T-1, 10*T+1, 3'h1);
        step(1, 1'b0, 8*T, 8*T, 3'h3);
        step(2, 1'b0, 8*T, 8*T, 3'h7);
        drive_en(1'b0);
        step(2, 1'b1, 9*T-1, 10*T+1, 3'h3);
        step(1, 1'b1, 8*T, 8*T, 3'h1);
        step(0, 1'b1, 8*T, 8*T, 3'h0);
        drive_en(1'b1);
        repeat (6*T) @(posedge clk_sys_i);
        enable_i <= 1'b0;
        repeat (20*T) @(posedge clk_sys_i);
        #1 check("glitch_pins", 3'h0, pin);
        drive_en(1'b1);
        step(0, 1'b0, 9*T-1, 10*T+1, 3'h1);
        drive_en(1'b0);
        step(0, 1'b1, 1, 12*T, 3'h0);
        @(posedge clk_sys_i);
        pol_flip <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 check("inv_idle_pins", 3'h7, pin);
        drive_en(1'b1);
        step(0, 1'b1, 9*T-1, 10*T+1, 3'h6);
        final_report();
    end
endmodule : test_rail_sequencer
`default_nettype wire
